//--- src/fpc_flash_ctrl.sv
// flash program, erase and protection sequencer with AXI4-Lite registers
// Operation
// - protection writes gate access checks immediately
// - address bit 0 selects commit target
// - commit bit writes selected register permanently
// - write bit held until programming completes
// - erase bit held until page erase completes
// - mass-erase bit held until array erased
// - protection loaded from storage at power-on
// - factory protection value is all ones
// - protection bits can only be cleared
// - uncommitted clears revert on power-on reset
// - one bit per 2 KB block, upper zero
// - two register bases, decoded by offset
// - raw, mask, masked status with write-one-clear
// - reload value times one microsecond ticks
// - program or erase of protected block refused
// - protected data reads return zero
`timescale 1ns/1ps
module fpc_flash_ctrl
    import fpc_pkg::*;
#(
    parameter int unsigned NBLK = FPC_NBLK
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // axi4-lite write address and data
    input wire logic [FPC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [FPC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // nonvolatile protection store
    input wire logic [NBLK-1:0] nv_read_enable,
    input wire logic [NBLK-1:0] nv_program_enable,
    output logic nv_write,
    output logic nv_sel_program,
    output logic [NBLK-1:0] nv_wdata,
    // flash array access check and operation
    input wire logic [31:0] rd_addr,
    input wire logic rd_is_fetch,
    input wire logic [31:0] rd_array_data,
    output logic [31:0] rd_data,
    output logic rd_denied,
    output logic [2:0] array_op,
    output logic [31:0] array_addr,
    output logic [31:0] array_wdata
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] flash_target_address;
    logic [31:0] flash_write_data;
    logic [3:0] cmd_bits;
    logic [1:0] flash_raw_irq_status;
    logic [1:0] flash_irq_mask;
    logic [NBLK-1:0] block_read_enable;
    logic [NBLK-1:0] block_program_enable;
    logic [7:0] microsecond_reload;
    fpc_state_e state;
    fpc_state_e next_state;
    fpc_tick_if tk();

    // sync of the nonvolatile store pins
    logic [NBLK-1:0] nvr_s1, nvr_s2, nvp_s1, nvp_s2;

    ////////////////////////////////////////////////////////////////////////
    // axi handshake
    logic aw_held, w_held;
    logic [FPC_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [11:0] wa = aw_addr;
    wire [11:0] ra = s_axi_araddr;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                         {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] wbits = w_data | ~wmask;

    // write decode
    wire wr_addr = wr_go && wa == FPC_OFS_ADDR;
    wire wr_data = wr_go && wa == FPC_OFS_DATA;
    wire wr_cmd = wr_go && wa == FPC_OFS_CMD;
    wire wr_im = wr_go && wa == FPC_OFS_IM;
    wire wr_mis = wr_go && wa == FPC_OFS_MIS;
    wire wr_rden = wr_go && wa == FPC_OFS_RDEN;
    wire wr_pgen = wr_go && wa == FPC_OFS_PGEN;
    wire wr_usec = wr_go && wa == FPC_OFS_USEC;
    wire wr_hit = wr_addr | wr_data | wr_cmd | wr_im | wr_mis | wr_rden
        | wr_pgen | wr_usec | (wr_go && wa == FPC_OFS_RIS);

    // keyed command accepted only when idle
    wire key_ok = w_data[31:FPC_KEY_LSB] == FPC_WRKEY && w_strb == 4'hf;
    wire cmd_go = wr_cmd && key_ok && state == FPC_IDLE
        && cmd_bits == 4'h0 && w_data[3:0] != 4'h0;
    wire [NBLK-1:0] tgt_blk_oh =
        NBLK'(1) << flash_target_address[FPC_BLK_LSB +: 4];
    // refused when target block may not change
    wire blk_locked = (block_program_enable & tgt_blk_oh) == '0;
    wire needs_blk = w_data[FPC_BIT_WRITE] | w_data[FPC_BIT_ERASE];
    wire mass_locked = block_program_enable != {NBLK{1'b1}};
    wire refuse = cmd_go && ((needs_blk && blk_locked)
        || (w_data[FPC_BIT_MASS_ERASE_BIT] && mass_locked));

    // pulse length per command, in microseconds
    wire [7:0] us_len =
        w_data[FPC_BIT_WRITE] ? 8'(FPC_PROG_US) :
        w_data[FPC_BIT_ERASE] ? 8'(FPC_ERASE_US) :
        w_data[FPC_BIT_MASS_ERASE_BIT] ? 8'(FPC_MASS_ERASE_BIT_US) : 8'(FPC_COMMIT_US);

    assign tk.start = cmd_go && !refuse;
    assign tk.reload = microsecond_reload;
    assign tk.us_len = us_len;

    fpc_pulse_timer u_timer (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .tk(tk)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            FPC_BOOT: next_state = FPC_IDLE;
            FPC_IDLE: if (tk.start) next_state = FPC_PULSE;
            FPC_PULSE: if (tk.done) next_state = FPC_FINISH;
            FPC_FINISH: next_state = FPC_IDLE;
            default: next_state = FPC_IDLE;
        endcase
    end

    wire op_done = state == FPC_FINISH;
    wire [1:0] irq_set = {refuse, op_done};
    wire [1:0] irq_clr = wr_mis ? wbits[1:0] & flash_irq_mask : 2'b00;
    wire commit_prog = flash_target_address[0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= FPC_BOOT;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // no reset: the pairs fill with the stored values while reset is held
    always_ff @(posedge clk) begin
        if (clk_en) begin
            nvr_s1 <= nv_read_enable;
            nvr_s2 <= nvr_s1;
            nvp_s1 <= nv_program_enable;
            nvp_s2 <= nvp_s1;
        end
    end

    // protection registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            block_read_enable <= FPC_PROT_FACTORY[NBLK-1:0];
            block_program_enable <= FPC_PROT_FACTORY[NBLK-1:0];
        end else if (clk_en) begin
            if (state == FPC_BOOT) begin
                // stored values replace volatile clears
                block_read_enable <= nvr_s2;
                block_program_enable <= nvp_s2;
            end else begin
                // write-zero-only, live at once
                if (wr_rden)
                    block_read_enable <= block_read_enable & wbits[NBLK-1:0];
                if (wr_pgen)
                    block_program_enable <=
                        block_program_enable & wbits[NBLK-1:0];
            end
        end
    end

    // software registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flash_target_address <= '0;
            flash_write_data <= '0;
            flash_irq_mask <= '0;
            microsecond_reload <= FPC_USEC_RST;
            flash_raw_irq_status <= '0;
            cmd_bits <= '0;
        end else if (clk_en) begin
            if (wr_addr)
                flash_target_address <= (flash_target_address & ~wmask)
                    | (w_data & wmask);
            if (wr_data)
                flash_write_data <= (flash_write_data & ~wmask)
                    | (w_data & wmask);
            if (wr_im && w_strb[0])
                flash_irq_mask <= w_data[1:0];
            if (wr_usec && w_strb[0])
                microsecond_reload <= w_data[7:0];
            // set wins over clear
            flash_raw_irq_status <= (flash_raw_irq_status & ~irq_clr)
                | irq_set;
            // held during the operation, cleared at its end
            if (tk.start)
                cmd_bits <= w_data[3:0];
            else if (op_done)
                cmd_bits <= '0;
        end
    end

    // outputs to the array and the nonvolatile store
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            array_op <= '0;
            array_addr <= '0;
            array_wdata <= '0;
            nv_write <= 1'b0;
            nv_sel_program <= 1'b0;
            nv_wdata <= '0;
        end else if (clk_en) begin
            array_op <= (state == FPC_PULSE) ? cmd_bits[2:0] : 3'b000;
            array_addr <= flash_target_address;
            array_wdata <= flash_write_data;
            // commit pulse to the store
            nv_write <= op_done && cmd_bits[FPC_BIT_COMMIT];
            nv_sel_program <= commit_prog;
            nv_wdata <= commit_prog ? block_program_enable
                : block_read_enable;
        end
    end

    // data read gating
    wire [NBLK-1:0] rd_blk_oh = NBLK'(1) << rd_addr[FPC_BLK_LSB +: 4];
    wire rd_blocked = !rd_is_fetch && (block_read_enable & rd_blk_oh) == '0;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data <= '0;
            rd_denied <= 1'b0;
        end else if (clk_en) begin
            rd_data <= rd_blocked ? 32'h0000_0000 : rd_array_data;
            rd_denied <= rd_blocked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    wire [1:0] mis = flash_raw_irq_status & flash_irq_mask;
    logic [31:0] rmux;
    logic rhit;
    always_comb begin
        rmux = '0;
        rhit = 1'b1;
        case (ra)
            FPC_OFS_ADDR: rmux = flash_target_address;
            FPC_OFS_DATA: rmux = flash_write_data;
            FPC_OFS_CMD: rmux = {28'h000_0000, cmd_bits};
            FPC_OFS_RIS: rmux = {30'h0, flash_raw_irq_status};
            FPC_OFS_IM: rmux = {30'h0, flash_irq_mask};
            FPC_OFS_MIS: rmux = {30'h0, mis};
            FPC_OFS_RDEN: rmux = 32'(block_read_enable);
            FPC_OFS_PGEN: rmux = 32'(block_program_enable);
            FPC_OFS_USEC: rmux = {24'h00_0000, microsecond_reload};
            default: rhit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= FPC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= FPC_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_held && !aw_take;
            s_axi_wready <= !w_held && !w_take;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[FPC_AW-1:2], 2'b00};
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? FPC_RESP_OKAY : FPC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            s_axi_arready <= !s_axi_rvalid && !rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rmux;
                s_axi_rresp <= rhit ? FPC_RESP_OKAY : FPC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

//--- src/fpc_pkg.sv
// constants, types and register map for the flash command sequencer
package fpc_pkg;
    localparam int unsigned FPC_AW = 12;
    // register byte offsets
    localparam logic [11:0] FPC_OFS_ADDR = 12'h000;
    localparam logic [11:0] FPC_OFS_DATA = 12'h004;
    localparam logic [11:0] FPC_OFS_CMD = 12'h008;
    localparam logic [11:0] FPC_OFS_RIS = 12'h00c;
    localparam logic [11:0] FPC_OFS_IM = 12'h010;
    localparam logic [11:0] FPC_OFS_MIS = 12'h014;
    localparam logic [11:0] FPC_OFS_RDEN = 12'h130;
    localparam logic [11:0] FPC_OFS_PGEN = 12'h134;
    localparam logic [11:0] FPC_OFS_USEC = 12'h140;
    // bus base addresses, the decoder above this block uses them
    localparam logic [31:0] FPC_CTRL_BASE = 32'h400f_d000;
    localparam logic [31:0] FPC_SYS_BASE = 32'h400f_e000;
    // command register fields
    localparam logic [15:0] FPC_WRKEY = 16'ha442;
    localparam int unsigned FPC_KEY_LSB = 16;
    localparam int unsigned FPC_BIT_WRITE = 0;
    localparam int unsigned FPC_BIT_ERASE = 1;
    localparam int unsigned FPC_BIT_MASS_ERASE_BIT = 2;
    localparam int unsigned FPC_BIT_COMMIT = 3;
    // interrupt bits
    localparam int unsigned FPC_IRQ_DONE = 0;
    localparam int unsigned FPC_IRQ_ACCESS = 1;
    // resets and sizes
    localparam logic [15:0] FPC_PROT_FACTORY = 16'hffff;
    localparam logic [7:0] FPC_USEC_RST = 8'h31;
    localparam int unsigned FPC_BLK_LSB = 11;
    localparam int unsigned FPC_NBLK = 16;
    // pulse lengths in microseconds
    localparam int unsigned FPC_PROG_US = 20;
    localparam int unsigned FPC_ERASE_US = 100;
    localparam int unsigned FPC_MASS_ERASE_BIT_US = 200;
    localparam int unsigned FPC_COMMIT_US = 20;
    localparam logic [1:0] FPC_RESP_OKAY = 2'b00;
    localparam logic [1:0] FPC_RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        FPC_IDLE, FPC_BOOT, FPC_PULSE, FPC_FINISH
    } fpc_state_e;
endpackage

//--- src/fpc_tick_if.sv
// carrier between the sequencer and its microsecond pulse timer
`timescale 1ns/1ps
interface fpc_tick_if;
    logic start;
    logic [7:0] reload;
    logic [7:0] us_len;
    logic done;
    modport ctrl (output start, output reload, output us_len, input done);
    modport timer (input start, input reload, input us_len, output done);
endinterface

//--- src/fpc_pulse_timer.sv
// microsecond tick divider and pulse length counter
`timescale 1ns/1ps
module fpc_pulse_timer
    import fpc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // control
    fpc_tick_if.timer tk
);
    logic [7:0] div;
    logic [7:0] us_left;
    logic busy;
    wire tick = busy && (div == 8'h00);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div <= 8'h00;
            us_left <= 8'h00;
            busy <= 1'b0;
            tk.done <= 1'b0;
        end else if (clk_en) begin
            tk.done <= 1'b0;
            if (tk.start) begin
                busy <= 1'b1;
                div <= tk.reload;
                us_left <= tk.us_len;
            end else if (tick) begin
                div <= tk.reload;
                us_left <= us_left - 8'h01;
                if (us_left <= 8'h01) begin
                    busy <= 1'b0;
                    tk.done <= 1'b1;
                end
            end else if (busy) begin
                div <= div - 8'h01;
            end
        end
    end
endmodule

//--- verif/fpc_flash_ctrl_asserts.sv
// port checker for the flash command sequencer
`timescale 1ns/1ps
module fpc_flash_ctrl_asserts
    import fpc_pkg::*;
#(
    parameter int unsigned NBLK = FPC_NBLK
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus
    input wire logic [FPC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [FPC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // store and array
    input wire logic nv_write,
    input wire logic nv_sel_program,
    input wire logic rd_is_fetch,
    input wire logic [31:0] rd_array_data,
    input wire logic [31:0] rd_data,
    input wire logic rd_denied,
    input wire logic [2:0] array_op
);
    ////////////////////////////////////////////////////////////////////////
    // last read offset and last address bit 0
    logic [FPC_AW-1:0] ar_q;
    logic sel_q;
    wire aw_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid;
    wire addr_wr = aw_hit && s_axi_wready && s_axi_awaddr == FPC_OFS_ADDR;
    wire prot_rd = ar_q == FPC_OFS_RDEN || ar_q == FPC_OFS_PGEN;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ar_q <= '0;
            sel_q <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_q <= s_axi_araddr;
            end
            if (addr_wr) begin
                sel_q <= s_axi_wdata[0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_held(logic b);
        b [*8];
    endsequence
    chk_prog_stands: assert property (
        $rose(array_op[0]) |-> s_held(array_op[0]))
        else $error("program pulse too short");
    chk_erase_stands: assert property (
        $rose(array_op[1]) |-> s_held(array_op[1]))
        else $error("page erase pulse too short");
    chk_mass_stands: assert property (
        $rose(array_op[2]) |-> s_held(array_op[2]))
        else $error("mass erase pulse too short");
    chk_op_single: assert property ($onehot0(array_op))
        else $error("more than one array operation");
    chk_commit_pulse: assert property (nv_write |=> !nv_write)
        else $error("store write longer than one cycle");
    chk_commit_sel: assert property (
        nv_write |-> nv_sel_program == sel_q)
        else $error("store target differs from address bit 0");
    chk_prot_upper: assert property (
        s_axi_rvalid && prot_rd |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("protection upper bits not zero");
    chk_fetch_open: assert property (rd_is_fetch |=> !rd_denied)
        else $error("instruction fetch refused");
    chk_denied_zero: assert property (
        rd_denied |-> rd_data == 32'h0000_0000)
        else $error("refused read returns data");
    chk_read_pass: assert property (
        !rd_denied && !$past(reset) |-> rd_data == $past(rd_array_data))
        else $error("allowed read data differs");
endmodule

bind fpc_flash_ctrl fpc_flash_ctrl_asserts #(.NBLK(NBLK))
    u_fpc_flash_ctrl_asserts (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .nv_write, .nv_sel_program, .rd_is_fetch, .rd_array_data, .rd_data,
    .rd_denied, .array_op
);

//--- verif/tb_fpc_flash_ctrl.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module tb_fpc_flash_ctrl;
    import fpc_pkg::*;
    logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, rd_is_fetch;
    logic [FPC_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rd_addr, rd_array_data, rnd, rv;
    logic [3:0] s_axi_wstrb;
    logic [15:0] nv_read_enable, nv_program_enable;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, nv_write, nv_sel_program, rd_denied;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, rd_data, array_addr, array_wdata;
    wire logic [15:0] nv_wdata;
    wire logic [2:0] array_op;
    logic [65:0] expq[$];
    logic [65:0] note;
    logic [16:0] nvw_seen;
    int n_mismatch, checks_done, cyc;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic [11:0] ofs [9] = '{FPC_OFS_ADDR, FPC_OFS_DATA, FPC_OFS_CMD,
        FPC_OFS_RIS, FPC_OFS_IM, FPC_OFS_MIS, FPC_OFS_RDEN, FPC_OFS_PGEN,
        FPC_OFS_USEC};
    logic [31:0] rstv [9] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_ffff,
        32'h0000_ffff, 32'h0000_0031};

    fpc_flash_ctrl u_fpc_flash_ctrl (
        .clk, .reset, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_read_enable,
        .nv_program_enable, .nv_write, .nv_sel_program, .nv_wdata,
        .rd_addr, .rd_is_fetch, .rd_array_data, .rd_data, .rd_denied,
        .array_op, .array_addr, .array_wdata
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) if (nv_write) nvw_seen <= {nv_sel_program, nv_wdata};
    // scoreboard: oldest note against each read answer
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            note = expq.pop_front();
            chk(s_axi_rresp, note[65:64]);
            if (note[63:32] != 0) chk(s_axi_rdata & note[63:32], note[31:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bail();
        n_mismatch++;
        tally_and_finish();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int k;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            k++;
        end while (!s_axi_bvalid && k < 200);
        if (k >= 200) bail();
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [11:0] a, input logic [65:0] n,
        output logic [31:0] d);
        int k;
        expq.push_back(n);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            k++;
        end while (!s_axi_rvalid && k < 200);
        if (k >= 200) bail();
        d = s_axi_rdata;
    endtask
    task automatic ex(input logic [11:0] a, input logic [31:0] m, e);
        logic [31:0] d;
        rd(a, {FPC_RESP_OKAY, m, e}, d);
    endtask
    // keyed command, poll until its bit clears, time the pulse
    task automatic op(input logic [31:0] a, d, input logic [3:0] b, int us);
        int t0, k;
        wr(FPC_OFS_DATA, d, FPC_RESP_OKAY);
        wr(FPC_OFS_ADDR, a, FPC_RESP_OKAY);
        wr(FPC_OFS_CMD, {FPC_WRKEY, 12'h000, b}, FPC_RESP_OKAY);
        t0 = cyc;
        rd(FPC_OFS_CMD, {FPC_RESP_OKAY, 64'h0}, rv);
        chk(rv[3:0], b);
        chk(array_op, b[2:0]);
        chk(array_addr, a);
        if (b[0]) chk(array_wdata, d);
        k = 0;
        while (rv[3:0] != 4'h0 && k < 5000) begin
            rd(FPC_OFS_CMD, {FPC_RESP_OKAY, 64'h0}, rv);
            k++;
        end
        if (k >= 5000) bail();
        chk(cyc - t0 >= 4 * us - 4 && cyc - t0 <= 4 * us + 40, 1);
    endtask
    task automatic arr(input logic [31:0] a, input logic f, den);
        rnd = xs(rnd);
        rd_addr <= a;
        rd_is_fetch <= f;
        rd_array_data <= rnd;
        repeat (2) @(posedge clk);
        chk(rd_denied, den);
        chk(rd_data, den ? 32'h0000_0000 : rnd);
    endtask
    task automatic boot();
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rd_is_fetch} = '0;
        {s_axi_bready, s_axi_rready} = 2'b11;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {rd_addr, rd_array_data, nvw_seen} = '0;
        {n_mismatch, checks_done, cyc} = '0;
        nv_read_enable = 16'hffff;
        nv_program_enable = 16'hffff;
        rnd = 32'h0000_004c;
        boot();
        foreach (ofs[i]) ex(ofs[i], ALL, rstv[i]);
        rd(12'h020, {FPC_RESP_SLVERR, ALL, 32'h0000_0000}, rv);
        wr(12'h020, 32'h0000_0001, FPC_RESP_SLVERR);
        wr(FPC_OFS_USEC, 32'h0000_0003, FPC_RESP_OKAY);
        ex(FPC_OFS_USEC, ALL, 32'h0000_0003);
        // byte strobes: address takes one byte, command is ignored
        wr(FPC_OFS_ADDR, 32'h1234_5678, FPC_RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        wr(FPC_OFS_ADDR, ALL, FPC_RESP_OKAY);
        wr(FPC_OFS_CMD, 32'ha442_0004, FPC_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        ex(FPC_OFS_ADDR, ALL, 32'h1234_56ff);
        ex(FPC_OFS_CMD, ALL, 32'h0000_0000);
        rnd = xs(rnd);
        op(32'h0000_0804, rnd, 4'h1, FPC_PROG_US);
        op(32'h0000_0400, 32'h0000_0000, 4'h2, FPC_ERASE_US);
        op(32'h0000_0000, 32'h0000_0000, 4'h4, FPC_MASS_ERASE_BIT_US);
        wr(FPC_OFS_IM, 32'h0000_0003, FPC_RESP_OKAY);
        ex(FPC_OFS_MIS, ALL, 32'h0000_0001);
        wr(FPC_OFS_MIS, 32'h0000_0001, FPC_RESP_OKAY);
        ex(FPC_OFS_RIS, ALL, 32'h0000_0000);
        wr(FPC_OFS_PGEN, 32'hffff_fffd, FPC_RESP_OKAY);
        wr(FPC_OFS_PGEN, ALL, FPC_RESP_OKAY);
        ex(FPC_OFS_PGEN, ALL, 32'h0000_fffd);
        wr(FPC_OFS_ADDR, 32'h0000_0804, FPC_RESP_OKAY);
        wr(FPC_OFS_CMD, 32'ha442_0001, FPC_RESP_OKAY);
        ex(FPC_OFS_CMD, 32'h0000_000f, 32'h0000_0000);
        chk(array_op, 3'b000);
        ex(FPC_OFS_RIS, 32'h0000_0002, 32'h0000_0002);
        wr(FPC_OFS_RDEN, 32'h0000_fff7, FPC_RESP_OKAY);
        arr(32'h0000_1800, 1'b0, 1'b1);
        arr(32'h0000_1804, 1'b1, 1'b0);
        arr(32'h0000_1000, 1'b0, 1'b0);
        op(32'h0000_0001, 32'h0000_0000, 4'h8, FPC_COMMIT_US);
        chk(nvw_seen, {1'b1, 16'hfffd});
        op(32'h0000_0000, 32'h0000_0000, 4'h8, FPC_COMMIT_US);
        chk(nvw_seen, {1'b0, 16'hfff7});
        // a clear left uncommitted must not survive the next boot
        wr(FPC_OFS_PGEN, 32'hffff_fff9, FPC_RESP_OKAY);
        ex(FPC_OFS_PGEN, ALL, 32'h0000_fff9);
        // store now holds the committed values only
        nv_program_enable <= 16'hfffd;
        nv_read_enable <= 16'hfff7;
        boot();
        ex(FPC_OFS_RDEN, ALL, 32'h0000_fff7);
        ex(FPC_OFS_PGEN, ALL, 32'h0000_fffd);
        ex(FPC_OFS_USEC, ALL, 32'h0000_0031);
        tally_and_finish();
    end
endmodule
